// *** logic/dshbp_pkg.sv ***
package dshbp_pkg;
	localparam int DSHBP_DATA_W = 8;
	localparam int DSHBP_CHANNELS = 2;
	localparam int DSHBP_SOURCES = 4;
	// Channel select and data/control select encodings
	localparam logic DSHBP_CHAN_A = 1'h0;
	localparam logic DSHBP_CHAN_B = 1'h1;
	localparam logic DSHBP_SEL_DATA = 1'h0;
	localparam logic DSHBP_SEL_CTRL = 1'h1;
	localparam logic [7:0] DSHBP_BYTE_ZERO = 8'h00;
	localparam logic [7:0] DSHBP_VECTOR_RESET = 8'h00;
	// Vector low bits carry the winning source when status affects vector
	localparam int DSHBP_VEC_CAUSE_LSB = 0;
	localparam int DSHBP_VEC_CAUSE_W = 3;

	typedef enum logic [1:0] {
		DSHBP_MODE_RW = 2'h0,
		DSHBP_MODE_IACK = 2'h1,
		DSHBP_MODE_DMA = 2'h3
	} dshbp_mode_type;

	typedef enum logic [2:0] {
		DSHBP_OP_NONE = 3'h0,
		DSHBP_OP_WR_CHAR = 3'h1,
		DSHBP_OP_RD_CHAR = 3'h3,
		DSHBP_OP_WR_CTRL = 3'h2,
		DSHBP_OP_RD_STAT = 3'h6
	} dshbp_op_type;
endpackage

// *** logic/dshbp_bus_if.sv ***
`timescale 1ns/1ps
interface dshbp_bus_if;
	import dshbp_pkg::*;
	logic chip_select_n;
	logic read_n;
	logic write_n;
	logic chan_sel;
	logic ctrl_sel;
	logic interrupt_acknowledge_in_n;
	logic dma_cycle;
	logic [DSHBP_DATA_W-1:0] host_data;
	logic [DSHBP_DATA_W-1:0] dev_data;
	logic dev_data_oe;
	logic interrupt_req_n;

	modport device (
		input chip_select_n, read_n, write_n, chan_sel, ctrl_sel,
		input interrupt_acknowledge_in_n, dma_cycle, host_data,
		output dev_data, dev_data_oe, interrupt_req_n
	);
	modport host (
		output chip_select_n, read_n, write_n, chan_sel, ctrl_sel,
		output interrupt_acknowledge_in_n, dma_cycle, host_data,
		input dev_data, dev_data_oe, interrupt_req_n
	);
endinterface

// *** logic/dshbp_device.sv ***
`timescale 1ns/1ps
module dshbp_device
	import dshbp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Host bus
	dshbp_bus_if.device bus,
	// Channel data path
	output logic [DSHBP_CHANNELS-1:0] tx_load,
	output logic [DSHBP_DATA_W-1:0] tx_char,
	input wire logic [DSHBP_CHANNELS*DSHBP_DATA_W-1:0] rx_char,
	output logic [DSHBP_CHANNELS-1:0] rx_taken,
	output logic [DSHBP_CHANNELS-1:0] ctrl_load,
	output logic [DSHBP_DATA_W-1:0] ctrl_byte,
	input wire logic [DSHBP_CHANNELS*DSHBP_DATA_W-1:0] status_byte,
	// Interrupt sources, index 0 highest priority
	input wire logic [DSHBP_SOURCES-1:0] irq_source,
	input wire logic vectored_enable,
	input wire logic status_affects_vector,
	input wire logic [DSHBP_DATA_W-1:0] base_vector,
	// Mode seen by the block
	output dshbp_mode_type bus_mode
);
	// ------------------------------
	// Transfer decode
	// ------------------------------
	function automatic dshbp_op_type decode_op(input logic cs_n, input logic rd_n,
		input logic wr_n, input logic cd);
		dshbp_op_type op;
		op = DSHBP_OP_NONE;
		if (!cs_n) begin
			if (!wr_n && rd_n) begin
				op = (cd == DSHBP_SEL_DATA) ? DSHBP_OP_WR_CHAR : DSHBP_OP_WR_CTRL;
			end else if (!rd_n && wr_n) begin
				op = (cd == DSHBP_SEL_DATA) ? DSHBP_OP_RD_CHAR : DSHBP_OP_RD_STAT;
			end
			// Both high stays idle; both low is illegal and ignored
		end
		return op;
	endfunction

	dshbp_op_type op_now;
	logic op_active_reg;
	logic op_start;
	logic chan;
	logic iack_active;

	assign op_now = decode_op(bus.chip_select_n, bus.read_n, bus.write_n, bus.ctrl_sel);
	assign chan = bus.chan_sel;
	assign op_start = (op_now != DSHBP_OP_NONE) && !op_active_reg;
	assign iack_active = !bus.interrupt_acknowledge_in_n;

	// ------------------------------
	// Mode
	// ------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bus_mode <= DSHBP_MODE_RW;
		end else if (iack_active) begin
			bus_mode <= DSHBP_MODE_IACK;
		end else if (bus.dma_cycle) begin
			bus_mode <= DSHBP_MODE_DMA;
		end else begin
			bus_mode <= DSHBP_MODE_RW;
		end
	end

	// ------------------------------
	// Strobe edge tracking
	// ------------------------------
	// One load per strobe, however long the host holds it
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			op_active_reg <= 1'h0;
		end else begin
			op_active_reg <= (op_now != DSHBP_OP_NONE);
		end
	end

	// ------------------------------
	// Writes
	// ------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_load <= '0;
			ctrl_load <= '0;
			tx_char <= DSHBP_BYTE_ZERO;
			ctrl_byte <= DSHBP_BYTE_ZERO;
		end else begin
			tx_load <= '0;
			ctrl_load <= '0;
			if (op_start && op_now == DSHBP_OP_WR_CHAR) begin
				tx_load[chan] <= 1'h1;
				tx_char <= bus.host_data;
			end
			if (op_start && op_now == DSHBP_OP_WR_CTRL) begin
				ctrl_load[chan] <= 1'h1;
				ctrl_byte <= bus.host_data;
			end
		end
	end

	// ------------------------------
	// Interrupt priority
	// ------------------------------
	logic [DSHBP_VEC_CAUSE_W-1:0] win_idx;
	logic win_any;
	logic [DSHBP_DATA_W-1:0] vector_value;

	always_comb begin
		win_idx = '0;
		win_any = 1'h0;
		for (int i = DSHBP_SOURCES - 1; i >= 0; i--) begin
			if (irq_source[i]) begin
				win_idx = DSHBP_VEC_CAUSE_W'(i);
				win_any = 1'h1;
			end
		end
	end

	always_comb begin
		vector_value = base_vector;
		if (status_affects_vector) begin
			vector_value[DSHBP_VEC_CAUSE_LSB +: DSHBP_VEC_CAUSE_W] = win_idx;
		end
	end

	// ------------------------------
	// Vector capture
	// ------------------------------
	// Frozen during acknowledge so late requests cannot change the vector
	logic [DSHBP_DATA_W-1:0] frozen_vector_reg;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			frozen_vector_reg <= DSHBP_VECTOR_RESET;
		end else if (!iack_active) begin
			frozen_vector_reg <= vector_value;
		end
	end

	// ------------------------------
	// Interrupt request
	// ------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bus.interrupt_req_n <= 1'h1;
		end else begin
			bus.interrupt_req_n <= !win_any;
		end
	end

	// ------------------------------
	// Byte lanes
	// ------------------------------
	// Channel A sits in the low byte, channel B above it
	function automatic logic [DSHBP_DATA_W-1:0] lane_byte(
		input logic [DSHBP_CHANNELS*DSHBP_DATA_W-1:0] lanes, input logic ch);
		return lanes[ch*DSHBP_DATA_W +: DSHBP_DATA_W];
	endfunction

	logic [DSHBP_DATA_W-1:0] rx_lane;
	logic [DSHBP_DATA_W-1:0] status_lane;
	assign rx_lane = lane_byte(rx_char, chan);
	assign status_lane = lane_byte(status_byte, chan);

	// ------------------------------
	// Read data and bus drive
	// ------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bus.dev_data <= DSHBP_BYTE_ZERO;
			bus.dev_data_oe <= 1'h0;
			rx_taken <= '0;
		end else begin
			rx_taken <= '0;
			bus.dev_data_oe <= 1'h0;
			if (iack_active && vectored_enable) begin
				bus.dev_data <= frozen_vector_reg;
				bus.dev_data_oe <= 1'h1;
			end else if (op_now == DSHBP_OP_RD_CHAR) begin
				bus.dev_data <= rx_lane;
				bus.dev_data_oe <= 1'h1;
				rx_taken[chan] <= op_start;
			end else if (op_now == DSHBP_OP_RD_STAT) begin
				bus.dev_data <= status_lane;
				bus.dev_data_oe <= 1'h1;
			end
		end
	end
endmodule

// *** logic/dshbp_host.sv ***
`timescale 1ns/1ps
module dshbp_host
	import dshbp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [1:0] req_addr,
	input wire logic [DSHBP_DATA_W-1:0] req_wdata,
	input wire logic req_iack,
	input wire logic req_dma,
	// Answer
	output logic rsp_valid,
	output logic [DSHBP_DATA_W-1:0] rsp_rdata,
	output logic rsp_driven,
	output logic irq_pending,
	// Device bus
	dshbp_bus_if.host bus
);
	// Strobe held two cycles so the device samples a stable level
	typedef enum logic [1:0] {
		DSHBP_H_IDLE = 2'h0,
		DSHBP_H_STROBE = 2'h1,
		DSHBP_H_HOLD = 2'h3,
		DSHBP_H_DONE = 2'h2
	} dshbp_hstate_type;

	dshbp_hstate_type state_reg;
	logic write_reg;
	logic iack_reg;

	assign req_ready = (state_reg == DSHBP_H_IDLE);
	assign irq_pending = !bus.interrupt_req_n;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg <= DSHBP_H_IDLE;
		end else begin
			unique case (state_reg)
				DSHBP_H_IDLE: begin
					if (req_valid) begin
						state_reg <= DSHBP_H_STROBE;
					end
				end
				DSHBP_H_STROBE: state_reg <= DSHBP_H_HOLD;
				DSHBP_H_HOLD: state_reg <= DSHBP_H_DONE;
				DSHBP_H_DONE: state_reg <= DSHBP_H_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			write_reg <= 1'h0;
			iack_reg <= 1'h0;
			bus.chan_sel <= DSHBP_CHAN_A;
			bus.ctrl_sel <= DSHBP_SEL_DATA;
			bus.host_data <= DSHBP_BYTE_ZERO;
			bus.dma_cycle <= 1'h0;
		end else if (state_reg == DSHBP_H_IDLE && req_valid) begin
			write_reg <= req_write;
			iack_reg <= req_iack;
			bus.chan_sel <= req_addr[0];
			bus.ctrl_sel <= req_addr[1];
			bus.host_data <= req_wdata;
			bus.dma_cycle <= req_dma;
		end else if (state_reg == DSHBP_H_DONE) begin
			bus.dma_cycle <= 1'h0;
		end
	end

	logic strobe_on;
	assign strobe_on = (state_reg == DSHBP_H_STROBE) || (state_reg == DSHBP_H_HOLD);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bus.chip_select_n <= 1'h1;
			bus.read_n <= 1'h1;
			bus.write_n <= 1'h1;
			bus.interrupt_acknowledge_in_n <= 1'h1;
		end else begin
			bus.chip_select_n <= !((state_reg == DSHBP_H_IDLE && req_valid && !req_iack)
				|| (strobe_on && state_reg != DSHBP_H_HOLD && !iack_reg));
			bus.write_n <= !(state_reg == DSHBP_H_IDLE && req_valid && !req_iack && req_write);
			bus.read_n <= !(state_reg == DSHBP_H_IDLE && req_valid && !req_iack && !req_write);
			bus.interrupt_acknowledge_in_n <= !(state_reg == DSHBP_H_IDLE && req_valid && req_iack);
			if (state_reg == DSHBP_H_STROBE) begin
				bus.chip_select_n <= iack_reg;
				bus.write_n <= !(write_reg && !iack_reg);
				bus.read_n <= !(!write_reg && !iack_reg);
				bus.interrupt_acknowledge_in_n <= !iack_reg;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rsp_valid <= 1'h0;
			rsp_rdata <= DSHBP_BYTE_ZERO;
			rsp_driven <= 1'h0;
		end else begin
			rsp_valid <= (state_reg == DSHBP_H_HOLD);
			if (state_reg == DSHBP_H_HOLD) begin
				rsp_rdata <= bus.dev_data_oe ? bus.dev_data : DSHBP_BYTE_ZERO;
				rsp_driven <= bus.dev_data_oe;
			end
		end
	end
endmodule

// *** dv/dshbp_props.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Bus protocol checks
// ----------------------------------------
module dshbp_props (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Bus signals
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic chan_sel,
	input wire logic ctrl_sel,
	input wire logic interrupt_acknowledge_in_n,
	input wire logic dma_cycle,
	input wire logic dev_data_oe
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// DMA cycles may strobe without chip select, so they are excluded
	a_deselect_quiet: assert property ((chip_select_n && !dma_cycle && interrupt_acknowledge_in_n) [*2] |-> !dev_data_oe)
		else $error("data driven while deselected");
	a_no_read_quiet: assert property ((read_n && interrupt_acknowledge_in_n) [*2] |-> !dev_data_oe)
		else $error("data driven without read");
	a_read_drives: assert property ((!chip_select_n && !read_n && write_n) |=> dev_data_oe)
		else $error("read not answered");
	a_read_release: assert property (($rose(read_n) && interrupt_acknowledge_in_n) |=> !dev_data_oe)
		else $error("data held after read");
	a_strobe_excl: assert property (!(!read_n && !write_n))
		else $error("both strobes low");
	a_strobe_cs: assert property (((!read_n || !write_n) && !dma_cycle) |-> !chip_select_n)
		else $error("strobe without chip select");
	a_read_hold: assert property ($fell(read_n) |-> !read_n [*2] ##1 read_n)
		else $error("read strobe width");
	a_write_hold: assert property ($fell(write_n) |-> !write_n [*2] ##1 write_n)
		else $error("write strobe width");
	a_sel_stable: assert property ((!chip_select_n ##1 !chip_select_n) |-> $stable(chan_sel) && $stable(ctrl_sel))
		else $error("selects moved in transfer");
endmodule

// *** dv/test_dshbp.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Bench for host and device ends
// ----------------------------------------
module test_dshbp
	import dshbp_pkg::*;
;
	logic ref_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic req_valid = 1'h0, req_write = 1'h0, req_iack = 1'h0, req_dma = 1'h0;
	logic [1:0] req_addr = 2'h0;
	logic [7:0] req_wdata = 8'h00, base_vector = 8'hA8, tx_char, ctrl_byte, rsp_rdata;
	logic [15:0] rx_char = 16'h9C1E, status_byte = 16'h7B42;
	logic [3:0] irq_source = 4'h0, mode_seen;
	logic vectored_enable = 1'h0, status_affects_vector = 1'h1;
	logic req_ready, rsp_valid, rsp_driven, irq_pending, got_drv;
	logic [1:0] tx_load, rx_taken, ctrl_load, tx_seen, rx_seen, ctrl_seen;
	logic [7:0] got_data, tx_b, ctrl_b;
	dshbp_mode_type bus_mode;
	int errors = 0, n_checks = 0, n_ld;
	always #12.5 ref_clk = ~ref_clk;
	dshbp_bus_if bus ();
	dshbp_device i_dshbp_device (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus),
		.tx_load(tx_load), .tx_char(tx_char), .rx_char(rx_char), .rx_taken(rx_taken),
		.ctrl_load(ctrl_load), .ctrl_byte(ctrl_byte), .status_byte(status_byte),
		.irq_source(irq_source), .vectored_enable(vectored_enable),
		.status_affects_vector(status_affects_vector), .base_vector(base_vector),
		.bus_mode(bus_mode));
	dshbp_host i_dshbp_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_iack(req_iack), .req_dma(req_dma),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_driven(rsp_driven),
		.irq_pending(irq_pending), .bus(bus));
	dshbp_props i_dshbp_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.chip_select_n(bus.chip_select_n), .read_n(bus.read_n), .write_n(bus.write_n),
		.chan_sel(bus.chan_sel), .ctrl_sel(bus.ctrl_sel),
		.interrupt_acknowledge_in_n(bus.interrupt_acknowledge_in_n),
		.dma_cycle(bus.dma_cycle), .dev_data_oe(bus.dev_data_oe));
	task automatic stop_test();
		if (errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One host request; pulses are tallied so a held strobe loading twice shows
	task automatic req(input logic wr, input logic [1:0] ad, input logic [7:0] wd,
		input logic ia, input logic dm);
		int i;
		{tx_seen, rx_seen, ctrl_seen, n_ld, mode_seen} = '0;
		@(posedge ref_clk);
		req_valid <= 1'h1;
		{req_write, req_addr, req_wdata, req_iack, req_dma} <= {wr, ad, wd, ia, dm};
		for (i = 0; i < 9; i++) begin
			@(negedge ref_clk);
			if (req_ready === 1'h1) break;
		end
		if (i == 9) begin
			errors++;
			stop_test();
		end
		@(posedge ref_clk);
		req_valid <= 1'h0;
		for (i = 0; i < 30; i++) begin
			@(negedge ref_clk);
			tx_seen |= tx_load;
			rx_seen |= rx_taken;
			ctrl_seen |= ctrl_load;
			n_ld += $countones({tx_load, rx_taken, ctrl_load});
			if (|tx_load) tx_b = tx_char;
			if (|ctrl_load) ctrl_b = ctrl_byte;
			mode_seen |= 4'h1 << bus_mode;
			if (rsp_valid === 1'h1) break;
		end
		{got_data, got_drv} = {rsp_rdata, rsp_driven};
		if (i == 30) begin
			errors++;
			stop_test();
		end
	endtask
	task automatic t_access(input logic wr);
		logic [7:0] wd, one;
		logic [15:0] src;
		for (int a = 0; a < 4; a++) begin
			wd = 8'h5A + 8'(a);
			req(wr, 2'(a), wd, 1'h0, 1'h0);
			one = 8'h01 << a[0];
			src = a[1] ? status_byte : rx_char;
			chk({6'h0, tx_seen}, (wr && !a[1]) ? one : 8'h00);
			chk({6'h0, ctrl_seen}, (wr && a[1]) ? one : 8'h00);
			chk({6'h0, rx_seen}, (!wr && !a[1]) ? one : 8'h00);
			chk(8'(n_ld), wr ? 8'h01 : {7'h0, !a[1]});
			chk({7'h0, got_drv}, {7'h0, !wr});
			chk({7'h0, mode_seen[3]}, 8'h00);
			chk(wr ? (a[1] ? ctrl_b : tx_b) : got_data, wr ? wd : (a[0] ? src[15:8] : src[7:0]));
		end
	endtask
	task automatic t_iack(input logic ven, input logic sav, input logic [3:0] src,
		input logic [7:0] vec);
		@(posedge ref_clk);
		{irq_source, vectored_enable, status_affects_vector} <= {src, ven, sav};
		repeat (3) @(negedge ref_clk);
		chk({7'h0, irq_pending}, 8'h01);
		req(1'h0, 2'h0, 8'h00, 1'h1, 1'h0);
		chk({7'h0, got_drv}, {7'h0, ven});
		chk({7'h0, mode_seen[1]}, 8'h01);
		if (ven) chk(got_data, vec);
		@(posedge ref_clk);
		irq_source <= 4'h0;
		repeat (3) @(negedge ref_clk);
		chk({7'h0, irq_pending}, 8'h00);
	endtask
	task automatic t_dma();
		req(1'h0, 2'h0, 8'h00, 1'h0, 1'h1);
		chk({7'h0, mode_seen[3]}, 8'h01);
		repeat (3) @(negedge ref_clk);
		chk({6'h0, bus_mode}, 8'h00);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'h0;
		t_access(1'h1);
		t_access(1'h0);
		t_iack(1'h1, 1'h1, 4'h6, 8'hA9);
		t_iack(1'h1, 1'h1, 4'hC, 8'hAA);
		t_iack(1'h1, 1'h0, 4'h2, 8'hA8);
		t_iack(1'h0, 1'h1, 4'h1, 8'h00);
		t_dma();
		stop_test();
	end
endmodule
